// [shared/acr_map.svh]
// Purpose: offsets, field positions, reset values and fixed codes of the config set
// Assumes: 8-bit registers at byte addresses on the serial register interface
// Notes: definitions only
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH
`define ACR_ADDR_STATUS 8'h00
`define ACR_ADDR_GENERAL 8'h01
`define ACR_ADDR_DATA_FMT 8'h02
`define ACR_ADDR_AVG 8'h03
`define ACR_ADDR_OPMODE 8'h04
`define ACR_ADDR_CHFUNC 8'h05
`define ACR_MASK_DATA_FMT 8'hB0
`define ACR_MASK_AVG 8'h07
`define ACR_MASK_OPMODE 8'hFF
`define ACR_MASK_CHFUNC 8'hFF
`define ACR_BIT_FIXPAT 7
`define ACR_BIT_TAG_HI 5
`define ACR_BIT_TAG_LO 4
`define ACR_BIT_HALT 7
`define ACR_BIT_MODE_HI 6
`define ACR_BIT_MODE_LO 5
`define ACR_BIT_OSC 4
`define ACR_BIT_DIV_HI 3
`define ACR_RESET_VALUE 8'h00
`define ACR_FIXED_CODE 12'hA5A
`endif

// [shared/acr_pkg.sv]
// Purpose: types of the config set
// Assumes: nothing
// Notes: constants live in acr_map.svh
package acr_pkg;
  typedef enum logic [1:0] {
    ACR_TAG_NONE = 2'h0,
    ACR_TAG_CHID = 2'h1,
    ACR_TAG_STAT = 2'h2,
    ACR_TAG_RSVD = 2'h3
  } acr_tag_t;
  typedef enum logic [2:0] {
    ACR_SEQ_RUN = 3'b001,
    ACR_SEQ_HALT = 3'b010,
    ACR_SEQ_IDLE = 3'b100
  } acr_seq_t;
endpackage : acr_pkg

// [src/acr_result_format.sv]
// Purpose: shapes one conversion result for readout
// Assumes: result and tag inputs valid when resultValid is high
// Notes: registered output, one cycle latency
`timescale 1ns/10ps
`include "acr_map.svh"
module acr_result_format (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controls
  input wire logic fixedPattern,
  input wire logic [1:0] appendTag,
  // result in
  input wire logic resultValid,
  input wire logic [11:0] resultCode,
  input wire logic [3:0] channelId,
  input wire logic [3:0] statusFlags,
  // result out
  output logic outValid,
  output logic [15:0] outWord,
  output logic outHasTag
);
  import acr_pkg::*;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic hasTag;
  } acr_fmt_state_t;
  acr_fmt_state_t st;
  acr_fmt_state_t next_st;
  logic [11:0] code;
  always_comb begin
    next_st = st;
    code = fixedPattern ? `ACR_FIXED_CODE : resultCode;
    next_st.valid = resultValid;
    if (resultValid) begin
      case (appendTag)
        ACR_TAG_CHID: begin
          next_st.word = {code, channelId};
          next_st.hasTag = 1'b1;
        end
        ACR_TAG_STAT: begin
          next_st.word = {code, statusFlags};
          next_st.hasTag = 1'b1;
        end
        default: begin
          // reserved code treated as no tag
          next_st.word = {4'h0, code};
          next_st.hasTag = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign outValid = st.valid;
  assign outWord = st.word;
  assign outHasTag = st.hasTag;
  a_fixed_code: assert property (@(posedge clk_sys) disable iff (rst)
    (resultValid && fixedPattern && appendTag == 2'h0) |=> outWord[11:0] == 12'hA5A)
    else $error("fixed pattern not returned");
  a_chid_tag: assert property (@(posedge clk_sys) disable iff (rst)
    (resultValid && appendTag == 2'h1) |=> outWord[3:0] == $past(channelId) && outHasTag)
    else $error("channel id not appended");
endmodule : acr_result_format

// [src/acr_config_regs.sv]
// Purpose: configuration register set of the eight-channel converter
// Assumes: serial interface core presents decoded byte writes and reads
// Notes: read data is registered, one cycle after regRd
`timescale 1ns/10ps
`include "acr_map.svh"
module acr_config_regs #(
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register access
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regWrBlocked,
  // device context
  input wire logic linkErrorFlag,
  input wire logic forceAllAnalog,
  input wire logic [NCH-1:0] gpioDirection,
  // results
  input wire logic resultValid,
  input wire logic [11:0] resultCode,
  input wire logic [3:0] channelId,
  input wire logic [3:0] statusFlags,
  output logic outValid,
  output logic [15:0] outWord,
  output logic outHasTag,
  // controls to the converter
  output logic [7:0] averageSamples,
  output logic autonomousMode,
  output logic lowPowerOsc,
  output logic [3:0] sampleRateDiv,
  output logic sequencingEnable,
  output logic [NCH-1:0] channelDigital,
  output logic [NCH-1:0] channelOutput
);
  import acr_pkg::*;
  typedef struct packed {
    logic [7:0] dataFmt;
    logic [7:0] avg;
    logic [7:0] opmode;
    logic [7:0] chfunc;
    logic [7:0] rdata;
    logic blocked;
    acr_seq_t seq;
    logic [7:0] avgCount;
    logic autoMode;
    logic lowPower;
    logic [3:0] div;
    logic seqEn;
    logic [NCH-1:0] digital;
    logic [NCH-1:0] dirOut;
  } acr_state_t;
  acr_state_t st;
  acr_state_t next_st;
  logic writeAllowed;
  logic allAnalog;
  logic [NCH-1:0] pinDigital;
  // ---------------------------------------------------------------
  // pin function with overrides
  // ---------------------------------------------------------------
  always_comb begin
    // while halted the stored field is kept, so release restores it
    allAnalog = forceAllAnalog || st.seq == ACR_SEQ_HALT;
  end
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_pin
      assign pinDigital[gi] = st.chfunc[gi] && !allAnalog;
    end
  endgenerate
  // ---------------------------------------------------------------
  // register file and sequencing control
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    writeAllowed = !linkErrorFlag || regAddr == `ACR_ADDR_STATUS ||
                   regAddr == `ACR_ADDR_GENERAL;
    next_st.blocked = regWr && !writeAllowed;
    if (regWr && writeAllowed) begin
      case (regAddr)
        `ACR_ADDR_DATA_FMT: next_st.dataFmt = regWdata & `ACR_MASK_DATA_FMT;
        `ACR_ADDR_AVG: next_st.avg = regWdata & `ACR_MASK_AVG;
        `ACR_ADDR_OPMODE: next_st.opmode = regWdata & `ACR_MASK_OPMODE;
        `ACR_ADDR_CHFUNC: next_st.chfunc = regWdata & `ACR_MASK_CHFUNC;
        default: next_st.blocked = 1'b0;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `ACR_ADDR_DATA_FMT: next_st.rdata = st.dataFmt & `ACR_MASK_DATA_FMT;
        `ACR_ADDR_AVG: next_st.rdata = st.avg & `ACR_MASK_AVG;
        `ACR_ADDR_OPMODE: next_st.rdata = st.opmode;
        `ACR_ADDR_CHFUNC: next_st.rdata = st.chfunc;
        default: next_st.rdata = 8'h00;
      endcase
    end
    case (st.seq)
      ACR_SEQ_RUN: begin
        if (linkErrorFlag && st.opmode[`ACR_BIT_HALT]) begin
          next_st.seq = ACR_SEQ_HALT;
        end else if (st.opmode[`ACR_BIT_MODE_HI:`ACR_BIT_MODE_LO] != 2'h1) begin
          next_st.seq = ACR_SEQ_IDLE;
        end
      end
      ACR_SEQ_HALT: begin
        if (!linkErrorFlag) begin
          next_st.seq = ACR_SEQ_RUN;
        end
      end
      ACR_SEQ_IDLE: begin
        if (st.opmode[`ACR_BIT_MODE_HI:`ACR_BIT_MODE_LO] == 2'h1) begin
          next_st.seq = ACR_SEQ_RUN;
        end
      end
      default: next_st.seq = ACR_SEQ_IDLE;
    endcase
    // a link error with the halt bit clear leaves sequencing alone
    next_st.seqEn = next_st.seq == ACR_SEQ_RUN;
    next_st.avgCount = 8'h01 << st.avg[2:0];
    next_st.autoMode = st.opmode[`ACR_BIT_MODE_HI:`ACR_BIT_MODE_LO] == 2'h1;
    next_st.lowPower = st.opmode[`ACR_BIT_OSC];
    next_st.div = st.opmode[`ACR_BIT_DIV_HI:0];
    next_st.digital = pinDigital;
    next_st.dirOut = pinDigital & gpioDirection;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
      st.seq <= ACR_SEQ_IDLE;
      st.avgCount <= 8'h01;
    end else begin
      st <= next_st;
    end
  end
  acr_result_format u_fmt (
    .clk_sys(clk_sys),
    .rst(rst),
    .fixedPattern(st.dataFmt[`ACR_BIT_FIXPAT]),
    .appendTag(st.dataFmt[`ACR_BIT_TAG_HI:`ACR_BIT_TAG_LO]),
    .resultValid(resultValid),
    .resultCode(resultCode),
    .channelId(channelId),
    .statusFlags(statusFlags),
    .outValid(outValid),
    .outWord(outWord),
    .outHasTag(outHasTag)
  );
  assign regRdata = st.rdata;
  assign regWrBlocked = st.blocked;
  assign averageSamples = st.avgCount;
  assign autonomousMode = st.autoMode;
  assign lowPowerOsc = st.lowPower;
  assign sampleRateDiv = st.div;
  assign sequencingEnable = st.seqEn;
  assign channelDigital = st.digital;
  assign channelOutput = st.dirOut;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_write_block: assert property (@(posedge clk_sys) disable iff (rst)
    (regWr && linkErrorFlag && regAddr == 8'h05) |=> $stable(st.chfunc))
    else $error("write accepted during link error");
  a_blocked_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (regWr && linkErrorFlag && regAddr == 8'h05) |=> regWrBlocked)
    else $error("refused write not flagged");
  a_status_unblocked: assert property (@(posedge clk_sys) disable iff (rst)
    (regWr && regAddr <= 8'h01) |=> !regWrBlocked)
    else $error("write to low addresses flagged");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (regRd && regAddr == 8'h03) |=> regRdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (rst)
    (regRd && regAddr > 8'h05) |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_reserved_wr: assert property (@(posedge clk_sys) disable iff (rst)
    (regWr && !linkErrorFlag && regAddr == 8'h02) |=> st.dataFmt[6] == 1'b0 &&
    st.dataFmt[3:0] == 4'h0)
    else $error("reserved bits stored");
  a_avg_count: assert property (@(posedge clk_sys) disable iff (rst)
    (st.avg[2:0] == 3'h7 && $stable(st.avg)) |=> averageSamples == 8'h80)
    else $error("averaging count wrong");
  // the flag must still stand a cycle later, or the halt is left at once
  a_halt_pause: assert property (@(posedge clk_sys) disable iff (rst)
    (st.seq == ACR_SEQ_RUN && linkErrorFlag && st.opmode[7]) ##1 linkErrorFlag |=>
    (!sequencingEnable && channelDigital == '0))
    else $error("no pause on link error");
  a_halt_resume: assert property (@(posedge clk_sys) disable iff (rst)
    (st.seq == ACR_SEQ_HALT && !linkErrorFlag) |=> sequencingEnable)
    else $error("sequencing not resumed after error cleared");
  a_keep_running: assert property (@(posedge clk_sys) disable iff (rst)
    (st.seq == ACR_SEQ_RUN && !st.opmode[7] && autonomousMode && $stable(st.opmode))
    |=> st.seq == ACR_SEQ_RUN)
    else $error("sequencing stopped with halt bit clear");
  a_manual_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (st.seq == ACR_SEQ_IDLE && st.opmode[6:5] == 2'h0) |=> !sequencingEnable)
    else $error("sequencer started in host-trigger mode");
  a_force_analog: assert property (@(posedge clk_sys) disable iff (rst)
    forceAllAnalog |=> channelDigital == '0)
    else $error("digital pin while forced analog");
  a_dir_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (channelOutput & ~channelDigital) == '0)
    else $error("output on analog channel");
  // outputs follow the field one cycle late, so compare against the earlier value
  a_osc_pick: assert property (@(posedge clk_sys) disable iff (rst)
    $stable(st.opmode) |=> lowPowerOsc == $past(st.opmode[4]) &&
    sampleRateDiv == $past(st.opmode[3:0]))
    else $error("oscillator or divider mismatch");
endmodule : acr_config_regs

// [testbench/acr_host_model.sv]
// Purpose: host controller on the register interface of the config set
// Assumes: strobes launched 1 ns after the rising edge, one cycle each
// Notes: released address and data lines carry the inverse of their last value
`timescale 1ns/10ps
module acr_host_model (
  // clock
  input wire logic clk_sys,
  // register access
  output logic regWr,
  output logic regRd,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // -------------------------------------------------------------
  // bus cycles
  // -------------------------------------------------------------
  // callers never pass the reserved tag or mode codes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clk_sys);
    #1;
    regWr = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    regRd = 1'b1;
    regAddr = a;
    @(posedge clk_sys);
    #1;
    q = regRdata;
    regRd = 1'b0;
    regAddr = ~a;
  endtask : rd
endmodule : acr_host_model

// [testbench/test_adc_config_register_set.sv]
// Purpose: self-checking bench of the config register set
// Assumes: derived outputs settle within three cycles of a write
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`include "acr_map.svh"
module test_adc_config_register_set;
  logic clk_sys, rst, regWr, regRd, regWrBlocked, linkErrorFlag, forceAllAnalog;
  logic resultValid, outValid, outHasTag, autonomousMode, lowPowerOsc, sequencingEnable;
  logic [7:0] regAddr, regWdata, regRdata, gpioDirection, averageSamples;
  logic [7:0] channelDigital, channelOutput;
  logic [11:0] resultCode;
  logic [3:0] channelId, statusFlags, sampleRateDiv;
  logic [15:0] outWord;
  int miscompares = 0, n_compared = 0, cycles = 0;
  acr_host_model hostU (.clk_sys(clk_sys), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  acr_config_regs dut_u (.clk_sys(clk_sys), .rst(rst), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regWrBlocked(regWrBlocked), .linkErrorFlag(linkErrorFlag),
    .forceAllAnalog(forceAllAnalog), .gpioDirection(gpioDirection),
    .resultValid(resultValid), .resultCode(resultCode), .channelId(channelId),
    .statusFlags(statusFlags), .outValid(outValid), .outWord(outWord),
    .outHasTag(outHasTag), .averageSamples(averageSamples),
    .autonomousMode(autonomousMode), .lowPowerOsc(lowPowerOsc),
    .sampleRateDiv(sampleRateDiv), .sequencingEnable(sequencingEnable),
    .channelDigital(channelDigital), .channelOutput(channelOutput));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    hostU.rd(a, q);
    chk(q, exp);
  endtask : rdchk
  // derived outputs lag a write by two cycles
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    for (int a = 2; a <= 5; a++) rdchk(8'(a), `ACR_RESET_VALUE);
    chk(averageSamples, 16'h0001);
    chk(channelDigital, 16'h0000);
    chk(sequencingEnable, 16'h0000);
  endtask : t_reset
  task automatic t_fields;
    hostU.wr(`ACR_ADDR_DATA_FMT, 8'h4F);
    rdchk(`ACR_ADDR_DATA_FMT, 8'h00);
    hostU.wr(`ACR_ADDR_AVG, 8'hFD);
    rdchk(`ACR_ADDR_AVG, 8'h05);
    for (int k = 0; k < 8; k++) begin
      hostU.wr(`ACR_ADDR_AVG, 8'(k));
      settle();
      chk(averageSamples, 16'(1 << k));
    end
    hostU.wr(`ACR_ADDR_OPMODE, 8'h3A);
    rdchk(`ACR_ADDR_OPMODE, 8'h3A);
    settle();
    chk(autonomousMode, 16'h0001);
    chk(lowPowerOsc, 16'h0001);
    chk(sampleRateDiv, 16'h000A);
    hostU.wr(`ACR_ADDR_OPMODE, 8'h05);
    settle();
    chk(autonomousMode, 16'h0000);
    chk(lowPowerOsc, 16'h0000);
    chk(sampleRateDiv, 16'h0005);
    rdchk(8'h06, 8'h00);
  endtask : t_fields
  task automatic t_format;
    logic [11:0] code;
    for (int fp = 0; fp < 2; fp++) for (int tg = 0; tg < 3; tg++) begin
      hostU.wr(`ACR_ADDR_DATA_FMT, {fp[0], 1'b0, tg[1:0], 4'h0});
      settle();
      resultValid = 1'b1;
      @(posedge clk_sys);
      #1;
      resultValid = 1'b0;
      code = fp ? `ACR_FIXED_CODE : resultCode;
      chk(outValid, 16'h0001);
      chk(outHasTag, 16'(tg != 0));
      chk(outWord, tg == 0 ? {4'h0, code} : {code, tg == 1 ? 4'h5 : 4'h9});
    end
  endtask : t_format
  task automatic t_pins;
    hostU.wr(`ACR_ADDR_CHFUNC, 8'hA5);
    settle();
    chk(channelDigital, 16'h00A5);
    chk(channelOutput, 16'h0005);
    forceAllAnalog = 1'b1;
    settle();
    chk(channelDigital, 16'h0000);
    chk(channelOutput, 16'h0000);
    forceAllAnalog = 1'b0;
  endtask : t_pins
  task automatic t_link;
    hostU.wr(`ACR_ADDR_OPMODE, 8'h20);
    settle();
    chk(sequencingEnable, 16'h0001);
    linkErrorFlag = 1'b1;
    settle();
    chk(sequencingEnable, 16'h0001);
    chk(channelDigital, 16'h00A5);
    hostU.wr(`ACR_ADDR_CHFUNC, 8'h00);
    chk(regWrBlocked, 16'h0001);
    rdchk(`ACR_ADDR_CHFUNC, 8'hA5);
    hostU.wr(`ACR_ADDR_GENERAL, 8'h00);
    chk(regWrBlocked, 16'h0000);
    linkErrorFlag = 1'b0;
    hostU.wr(`ACR_ADDR_OPMODE, 8'hA0);
    linkErrorFlag = 1'b1;
    settle();
    chk(sequencingEnable, 16'h0000);
    chk(channelDigital, 16'h0000);
    linkErrorFlag = 1'b0;
    settle();
    chk(sequencingEnable, 16'h0001);
    chk(channelDigital, 16'h00A5);
  endtask : t_link
  // -------------------------------------------------------------
  // clock, watchdog and main sequence
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("ERROR %0t run did not finish in time", $time);
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    linkErrorFlag = 1'b0;
    forceAllAnalog = 1'b0;
    gpioDirection = 8'h0F;
    resultValid = 1'b0;
    resultCode = 12'h123;
    channelId = 4'h5;
    statusFlags = 4'h9;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_fields();
    t_format();
    t_pins();
    t_link();
    conclude();
  end
endmodule : test_adc_config_register_set
